// >>> spdif_status_user_buffer_regs.sv
/*
  Control, non-audio status, channel-status buffers and user-bit
  buffer access for the digital audio receiver and transmitter.
  Assumes a host port decoded from the serial control port, and
  receiver and transmitter logic on the same clock.
*/
// Functional notes
// - Mute bit silences the transmitter output
// - Bits 2:1 choose converter de-emphasis filter
// - Read-only status holds four non-audio flags
// - Bit 3 shows compressed-surround preamble detection
// - Receive channel status: 24 bytes from 0x20
// - Receive professional flag is byte 0x20 bit 0
// - Receive status buffer read-only unless autobuffering
// - Transmit channel status: 24 bytes from 0x38
// - Transmit professional flag is byte 0x38 bit 0
// - Autobuffering replaces host transmit status with relayed
// - Pointer at 0x50 selects receive user byte
// - Read at 0x51 returns pointed receive byte
// - Receive user buffer writable only when autobuffering
// - Pointer at 0x52 selects transmit user byte
// - Write at 0x53 stores pointed transmit byte
`timescale 1ns/100ps

module spdif_status_user_buffer_regs
  import spdif_regs_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire spdif_regs_pkg::host_req_t host_req,
  output      logic [7:0]                host_rdata,
  input  wire logic                      cs_autobuf_en,
  input  wire logic                      user_autobuf_en,
  input  wire spdif_regs_pkg::nonaudio_t nonaudio_flags,
  input  wire spdif_regs_pkg::cs_wr_t    rx_cs_wr,
  input  wire spdif_regs_pkg::user_wr_t  rx_user_wr,
  input  wire logic [4:0]                tx_cs_rd_idx,
  output      logic [7:0]                tx_cs_byte,
  input  wire logic [7:0]                tx_user_rd_addr,
  output      logic [7:0]                tx_user_byte,
  output      logic                      transmitter_silence,
  output      deemph_sel_t               rate_conv_deemph_select,
  output      logic                      rx_professional_use_flag,
  output      logic                      tx_professional_use_flag
);
  import spdif_regs_pkg::*;

  // Returns hit flag and buffer index for a channel-status window
  function automatic logic [5:0] cs_decode(input logic [6:0] addr,
                                           input logic [6:0] base);
    logic [6:0] off;
    off = addr - base;
    cs_decode = {(addr >= base) && (off < CS_LEN_A), off[4:0]};
  endfunction

  // True when a byte index falls inside a channel-status buffer
  function automatic logic cs_in_range(input logic [4:0] idx);
    cs_in_range = (idx < CS_IDX_W'(CS_LEN));
  endfunction

  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [3:0] status;
  logic [3:0] next_status;
  logic [7:0] rx_cs      [CS_LEN];
  logic [7:0] next_rx_cs [CS_LEN];
  logic [7:0] tx_cs      [CS_LEN];
  logic [7:0] next_tx_cs [CS_LEN];
  logic [7:0] rx_user_pointer;
  logic [7:0] next_rx_user_pointer;
  logic [7:0] tx_user_pointer;
  logic [7:0] next_tx_user_pointer;
  logic [7:0] next_host_rdata;
  logic [7:0] next_tx_cs_byte;
  logic [7:0] next_tx_user_byte;
  logic       next_rx_pro;
  logic       next_tx_pro;
  logic [5:0] rx_dec;
  logic [5:0] tx_dec;
  logic       rx_cs_hit;
  logic       tx_cs_hit;
  logic [4:0] rx_cs_idx;
  logic [4:0] tx_cs_idx;
  logic       host_wr_ctrl;
  logic       host_wr_rx_ptr;
  logic       host_wr_tx_ptr;
  logic       host_wr_rx_user;
  logic       host_wr_tx_user;
  user_wr_t   rx_ram_wr;
  user_wr_t   tx_ram_wr;
  logic [7:0] rx_user_byte;
  logic [7:0] rx_relay_byte;
  logic [7:0] tx_user_host_byte;
  logic [7:0] tx_user_link_byte;
  logic [7:0] out_cs     [CS_LEN];
  logic       host_rd_ctrl;
  logic       host_rd_status;
  logic       host_rd_rx_ptr;
  logic       host_rd_rx_user;
  logic       host_rd_tx_ptr;
  logic       host_rd_tx_user;

  // Address decode
  assign rx_dec    = cs_decode(host_req.addr, RX_CHAN_STATUS_BASE);
  assign tx_dec    = cs_decode(host_req.addr, TX_CHAN_STATUS_BASE);
  assign rx_cs_hit = rx_dec[5];
  assign rx_cs_idx = rx_dec[4:0];
  assign tx_cs_hit = tx_dec[5];
  assign tx_cs_idx = tx_dec[4:0];

  assign host_wr_ctrl    = host_req.wr
                           && (host_req.addr == TX_MUTE_DEEMPH_CTRL_ADDR);
  assign host_wr_rx_ptr  = host_req.wr
                           && (host_req.addr == RX_USER_POINTER_ADDR);
  assign host_wr_tx_ptr  = host_req.wr
                           && (host_req.addr == TX_USER_POINTER_ADDR);
  assign host_wr_rx_user = host_req.wr && user_autobuf_en
                           && (host_req.addr == RX_USER_BYTE_ADDR);
  assign host_wr_tx_user = host_req.wr
                           && (host_req.addr == TX_USER_BYTE_ADDR);

  assign host_rd_ctrl    = host_req.rd
                           && (host_req.addr == TX_MUTE_DEEMPH_CTRL_ADDR);
  assign host_rd_status  = host_req.rd
                           && (host_req.addr == NONAUDIO_DETECT_STATUS_ADDR);
  assign host_rd_rx_ptr  = host_req.rd
                           && (host_req.addr == RX_USER_POINTER_ADDR);
  assign host_rd_rx_user = host_req.rd
                           && (host_req.addr == RX_USER_BYTE_ADDR);
  assign host_rd_tx_ptr  = host_req.rd
                           && (host_req.addr == TX_USER_POINTER_ADDR);
  assign host_rd_tx_user = host_req.rd
                           && (host_req.addr == TX_USER_BYTE_ADDR);

  // Control and status registers
  always_comb begin
    next_ctrl = ctrl;
    if (host_wr_ctrl) begin
      next_ctrl = host_req.wdata & CTRL_WMASK;
    end
    next_status                 = '0;
    next_status[PREAMBLE_BIT]   = nonaudio_flags.preamble;
    next_status[FRAME_BIT]      = nonaudio_flags.frame;
    next_status[SUBFRAME_A_BIT] = nonaudio_flags.subframe_a;
    next_status[SUBFRAME_B_BIT] = nonaudio_flags.subframe_b;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl   <= CTRL_RESET;
      status <= '0;
    end else begin
      ctrl   <= next_ctrl;
      status <= next_status;
    end
  end

  assign transmitter_silence     = ctrl[SILENCE_BIT];
  assign rate_conv_deemph_select =
    deemph_sel_t'(ctrl[DEEMPH_LSB +: 2]);

  // Channel-status buffers
  always_comb begin
    next_rx_cs = rx_cs;
    next_tx_cs = tx_cs;
    if (host_req.wr && rx_cs_hit && cs_autobuf_en) begin
      next_rx_cs[rx_cs_idx] = host_req.wdata;
    end
    if (rx_cs_wr.we && cs_in_range(rx_cs_wr.idx)) begin
      next_rx_cs[rx_cs_wr.idx] = rx_cs_wr.data;
    end
    if (host_req.wr && tx_cs_hit && !cs_autobuf_en) begin
      next_tx_cs[tx_cs_idx] = host_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < CS_LEN; i++) begin
        rx_cs[i] <= BYTE_RESET;
        tx_cs[i] <= BYTE_RESET;
      end
    end else begin
      rx_cs <= next_rx_cs;
      tx_cs <= next_tx_cs;
    end
  end

  // Outgoing channel status, relayed receive bytes while autobuffering
  always_comb begin
    for (int i = 0; i < CS_LEN; i++) begin
      out_cs[i] = cs_autobuf_en ? rx_cs[i] : tx_cs[i];
    end
  end

  // User-bit pointers
  always_comb begin
    next_rx_user_pointer = rx_user_pointer;
    next_tx_user_pointer = tx_user_pointer;
    if (host_wr_rx_ptr) begin
      next_rx_user_pointer = host_req.wdata;
    end
    if (host_wr_tx_ptr) begin
      next_tx_user_pointer = host_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_user_pointer <= POINTER_RESET;
      tx_user_pointer <= POINTER_RESET;
    end else begin
      rx_user_pointer <= next_rx_user_pointer;
      tx_user_pointer <= next_tx_user_pointer;
    end
  end

  // User-bit buffer write ports; the receiver wins over the host
  always_comb begin
    rx_ram_wr = rx_user_wr;
    if (!rx_user_wr.we && host_wr_rx_user) begin
      rx_ram_wr.we   = 1'b1;
      rx_ram_wr.addr = rx_user_pointer;
      rx_ram_wr.data = host_req.wdata;
    end
    tx_ram_wr.we   = host_wr_tx_user;
    tx_ram_wr.addr = tx_user_pointer;
    tx_ram_wr.data = host_req.wdata;
  end

  user_byte_ram #(
    .DEPTH (USER_DEPTH),
    .AW    (USER_AW)
  ) u_rx_user_ram (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr        (rx_ram_wr),
    .rd_addr_a (rx_user_pointer),
    .rd_data_a (rx_user_byte),
    .rd_addr_b (tx_user_rd_addr),
    .rd_data_b (rx_relay_byte)
  );

  user_byte_ram #(
    .DEPTH (USER_DEPTH),
    .AW    (USER_AW)
  ) u_tx_user_ram (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr        (tx_ram_wr),
    .rd_addr_a (tx_user_pointer),
    .rd_data_a (tx_user_host_byte),
    .rd_addr_b (tx_user_rd_addr),
    .rd_data_b (tx_user_link_byte)
  );

  // Host read data and transmitter-facing data
  always_comb begin
    next_host_rdata = '0;
    if (host_req.rd) begin
      if (host_rd_ctrl) begin
        next_host_rdata = ctrl;
      end else if (host_rd_status) begin
        next_host_rdata = {4'h0, status};
      end else if (rx_cs_hit) begin
        next_host_rdata = rx_cs[rx_cs_idx];
      end else if (tx_cs_hit) begin
        next_host_rdata = cs_autobuf_en ? 8'h00 : tx_cs[tx_cs_idx];
      end else if (host_rd_rx_ptr) begin
        next_host_rdata = rx_user_pointer;
      end else if (host_rd_rx_user) begin
        next_host_rdata = rx_user_byte;
      end else if (host_rd_tx_ptr) begin
        next_host_rdata = tx_user_pointer;
      end else if (host_rd_tx_user) begin
        next_host_rdata = tx_user_host_byte;
      end
    end
    next_tx_cs_byte = '0;
    if (cs_in_range(tx_cs_rd_idx)) begin
      next_tx_cs_byte = out_cs[tx_cs_rd_idx];
    end
    next_tx_user_byte = user_autobuf_en ? rx_relay_byte : tx_user_link_byte;
    next_rx_pro = rx_cs[0][PRO_FLAG_BIT];
    next_tx_pro = out_cs[0][PRO_FLAG_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_rdata               <= '0;
      tx_cs_byte               <= '0;
      tx_user_byte             <= '0;
      rx_professional_use_flag <= 1'b0;
      tx_professional_use_flag <= 1'b0;
    end else begin
      host_rdata               <= next_host_rdata;
      tx_cs_byte               <= next_tx_cs_byte;
      tx_user_byte             <= next_tx_user_byte;
      rx_professional_use_flag <= next_rx_pro;
      tx_professional_use_flag <= next_tx_pro;
    end
  end

endmodule // spdif_status_user_buffer_regs

// >>> spdif_regs_pkg.sv
/*
  Shared constants and carrier types for the digital audio interface
  status, channel-status and user-bit buffer registers.
  Assumes one 25 MHz clock domain and a host port with 7-bit addresses.
*/
package spdif_regs_pkg;

  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam int          CS_LEN         = 24;
  localparam int          CS_IDX_W       = 5;
  localparam int          USER_DEPTH     = 256;
  localparam int          USER_AW        = 8;

  // Register offsets
  localparam logic [6:0]  TX_MUTE_DEEMPH_CTRL_ADDR    = 7'h1E;
  localparam logic [6:0]  NONAUDIO_DETECT_STATUS_ADDR = 7'h1F;
  localparam logic [6:0]  RX_CHAN_STATUS_BASE         = 7'h20;
  localparam logic [6:0]  TX_CHAN_STATUS_BASE         = 7'h38;
  localparam logic [6:0]  RX_USER_POINTER_ADDR        = 7'h50;
  localparam logic [6:0]  RX_USER_BYTE_ADDR           = 7'h51;
  localparam logic [6:0]  TX_USER_POINTER_ADDR        = 7'h52;
  localparam logic [6:0]  TX_USER_BYTE_ADDR           = 7'h53;
  localparam logic [6:0]  CS_LEN_A                    = 7'h18;

  // Field positions
  localparam int          SILENCE_BIT    = 5;
  localparam int          DEEMPH_LSB     = 1;
  localparam int          PRO_FLAG_BIT   = 0;
  localparam int          PREAMBLE_BIT   = 3;
  localparam int          FRAME_BIT      = 2;
  localparam int          SUBFRAME_A_BIT = 1;
  localparam int          SUBFRAME_B_BIT = 0;

  // Reset values and writable masks
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_WMASK     = 8'h26;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [7:0]  POINTER_RESET  = 8'h00;

  typedef enum logic [1:0] {
    DEEMPH_NONE,
    DEEMPH_32K,
    DEEMPH_44K1,
    DEEMPH_48K
  } deemph_sel_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       we;
    logic [4:0] idx;
    logic [7:0] data;
  } cs_wr_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } user_wr_t;

  typedef struct packed {
    logic preamble;
    logic frame;
    logic subframe_a;
    logic subframe_b;
  } nonaudio_t;

endpackage

// >>> user_byte_ram.sv
/*
  Byte-wide user-bit buffer with one write port and two
  asynchronous read ports.
  Assumes the caller resolves write priority before this port.
*/
`timescale 1ns/100ps

module user_byte_ram #(
  parameter int DEPTH = spdif_regs_pkg::USER_DEPTH,
  parameter int AW    = spdif_regs_pkg::USER_AW
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire spdif_regs_pkg::user_wr_t wr,
  input  wire logic [AW-1:0]            rd_addr_a,
  output      logic [7:0]               rd_data_a,
  input  wire logic [AW-1:0]            rd_addr_b,
  output      logic [7:0]               rd_data_b
);
  import spdif_regs_pkg::*;

  logic [7:0] mem      [DEPTH];
  logic [7:0] next_mem [DEPTH];

  always_comb begin
    next_mem = mem;
    if (wr.we) begin
      next_mem[wr.addr[AW-1:0]] = wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= BYTE_RESET;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

endmodule // user_byte_ram

// >>> spdif_regs_monitor.sv
/*
  Checker for the status and buffer register block.
  Bound to that block; sees its ports only.
*/
`timescale 1ns/100ps

module spdif_regs_monitor
  import spdif_regs_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rst_b,
  input wire spdif_regs_pkg::host_req_t host_req,
  input wire logic [7:0]                host_rdata,
  input wire logic                      cs_autobuf_en,
  input wire spdif_regs_pkg::nonaudio_t nonaudio_flags,
  input wire spdif_regs_pkg::cs_wr_t    rx_cs_wr,
  input wire logic [4:0]                tx_cs_rd_idx,
  input wire logic [7:0]                tx_cs_byte,
  input wire logic                      transmitter_silence,
  input wire deemph_sel_t               rate_conv_deemph_select,
  input wire logic                      rx_professional_use_flag,
  input wire logic                      tx_professional_use_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr(a); host_req.wr && host_req.addr == a; endsequence
  logic host_pro_wr;
  assign host_pro_wr = host_req.wr && host_req.addr == 7'h20;

  sequence s_rd(a); host_req.rd && host_req.addr == a; endsequence
  sequence s_pro_wr;
    rx_cs_wr.we && rx_cs_wr.idx == 5'h00 ##1
    !(rx_cs_wr.we && rx_cs_wr.idx == 5'h00) && !host_pro_wr;
  endsequence

  property p_silence;
    s_wr(7'h1E) |=> transmitter_silence == $past(host_req.wdata[5]);
  endproperty
  a_silence: assert property (p_silence)
    else $error("mute output wrong");
  property p_deemph;
    s_wr(7'h1E) |=> rate_conv_deemph_select == $past(host_req.wdata[2:1]);
  endproperty
  a_deemph: assert property (p_deemph)
    else $error("filter select wrong");
  property p_status;
    $past(rst_b) ##0 s_rd(7'h1F)
      |=> host_rdata == {4'h0, $past(nonaudio_flags, 2)};
  endproperty
  a_status: assert property (p_status)
    else $error("status read wrong");
  property p_ctrl_res;
    s_rd(7'h1E) |=> (host_rdata & ~CTRL_WMASK) == 8'h00;
  endproperty
  a_ctrl_res: assert property (p_ctrl_res)
    else $error("reserved bits set");
  property p_rx_pro;
    s_pro_wr |=> rx_professional_use_flag == $past(rx_cs_wr.data[0], 2);
  endproperty
  a_rx_pro: assert property (p_rx_pro)
    else $error("receive flag wrong");
  property p_cs_range;
    tx_cs_rd_idx > 5'h17 |=> tx_cs_byte == 8'h00;
  endproperty
  a_cs_range: assert property (p_cs_range)
    else $error("status index beyond 24");
  property p_tx_rd_auto;
    cs_autobuf_en && host_req.rd && host_req.addr inside {[7'h38:7'h4F]}
      |=> host_rdata == 8'h00;
  endproperty
  a_tx_rd_auto: assert property (p_tx_rd_auto)
    else $error("disabled buffer read");
  property p_tx_pro;
    cs_autobuf_en |=> tx_professional_use_flag == rx_professional_use_flag;
  endproperty
  a_tx_pro: assert property (p_tx_pro)
    else $error("relayed flag wrong");
endmodule // spdif_regs_monitor

bind spdif_status_user_buffer_regs spdif_regs_monitor u_mon (
  .clk, .rst_b, .host_req, .host_rdata, .cs_autobuf_en, .nonaudio_flags,
  .rx_cs_wr, .tx_cs_rd_idx, .tx_cs_byte, .transmitter_silence,
  .rate_conv_deemph_select, .rx_professional_use_flag,
  .tx_professional_use_flag);

// >>> host_model.sv
/*
  Host controller model driving the decoded register port.
  Assumes requests launch on the falling clock edge.
*/
`timescale 1ns/100ps

module host_model
  import spdif_regs_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic [7:0]                host_rdata,
  output      spdif_regs_pkg::host_req_t host_req
);
  initial host_req = '0;

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    host_req <= '0;
    @(negedge clk);
  endtask

  // Data lines carry a changing pattern during reads
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: {1'b0, ~a}};
    @(negedge clk);
    d = host_rdata;
    host_req <= '0;
    @(negedge clk);
  endtask
endmodule // host_model

// >>> tb.sv
/*
  Self-checking bench for the status and buffer register block.
  Assumes the host model and the bound checker are compiled too.
*/
`timescale 1ns/100ps

module tb;
  import spdif_regs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  host_req_t   host_req;
  logic [7:0]  host_rdata, tx_cs_byte, tx_user_byte;
  logic        cs_autobuf_en = 1'b0;
  logic        user_autobuf_en = 1'b0;
  nonaudio_t   nonaudio_flags = '0;
  cs_wr_t      rx_cs_wr = '0;
  user_wr_t    rx_user_wr = '0;
  logic [4:0]  tx_cs_rd_idx = '0;
  logic [7:0]  tx_user_rd_addr = '0;
  logic        silence, rx_pro, tx_pro;
  deemph_sel_t deemph;
  int          fail_count = 0;
  int          checked = 0;

  always #20 clk = ~clk;

  spdif_status_user_buffer_regs u_dut (.clk, .rst_b, .host_req,
    .host_rdata, .cs_autobuf_en, .user_autobuf_en, .nonaudio_flags,
    .rx_cs_wr, .rx_user_wr, .tx_cs_rd_idx, .tx_cs_byte, .tx_user_rd_addr,
    .tx_user_byte, .transmitter_silence(silence),
    .rate_conv_deemph_select(deemph), .rx_professional_use_flag(rx_pro),
    .tx_professional_use_flag(tx_pro));
  host_model u_host (.clk, .host_rdata, .host_req);

  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & CTRL_WMASK;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic pulse_cs(input logic [4:0] i, input logic [7:0] d);
    rx_cs_wr <= '{we: 1'b1, idx: i, data: d};
    @(negedge clk);
    rx_cs_wr <= '0;
    @(negedge clk);
  endtask
  task automatic txsel(input logic [4:0] i, input logic [7:0] a);
    tx_cs_rd_idx <= i;
    tx_user_rd_addr <= a;
    @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(negedge clk);
    fail_count++;
    complete_run();
  end

  initial begin
    logic [7:0] d, e, p;
    int         i;
    i = $urandom(32'h3c03);
    repeat (6) @(negedge clk);
    rst_b <= 1'b1;
    rchk(7'h1E, CTRL_RESET);
    rchk(7'h50, POINTER_RESET);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d[2:1] = 2'(i);
      d[5] = i[0];
      u_host.wr(7'h1E, d);
      chk(8'(silence), 8'(d[5]));
      chk(8'(deemph), 8'(i));
      rchk(7'h1E, ctrl_exp(d));
    end
    $display("test control done");
    for (i = 0; i < 4; i++) begin
      nonaudio_flags <= (i == 0) ? nonaudio_t'(4'h8)
                                 : nonaudio_t'(4'($urandom));
      u_host.wr(7'h1F, 8'hFF);
      rchk(7'h1F, {4'h0, nonaudio_flags});
    end
    $display("test status done");
    d = 8'($urandom);
    pulse_cs(5'd0, d);
    chk(8'(rx_pro), 8'(d[0]));
    pulse_cs(5'd23, 8'hA5);
    pulse_cs(5'd24, 8'h5A);
    rchk(7'h20, d);
    rchk(7'h37, 8'hA5);
    u_host.wr(7'h20, ~d);
    rchk(7'h20, d);
    cs_autobuf_en <= 1'b1;
    u_host.wr(7'h20, ~d);
    rchk(7'h20, ~d);
    u_host.wr(7'h38, 8'h3C);
    txsel(5'd0, 8'h00);
    chk(tx_cs_byte, ~d);
    chk(8'(tx_pro), {7'h00, ~d[0]});
    rchk(7'h38, 8'h00);
    cs_autobuf_en <= 1'b0;
    rchk(7'h38, BYTE_RESET);
    e = 8'($urandom) | 8'h01;
    u_host.wr(7'h38, e);
    u_host.wr(7'h4F, 8'hC3);
    rchk(7'h38, e);
    chk(8'(tx_pro), 8'h01);
    txsel(5'd23, 8'h00);
    chk(tx_cs_byte, 8'hC3);
    txsel(5'd24, 8'h00);
    chk(tx_cs_byte, 8'h00);
    $display("test channel status done");
    p = 8'($urandom);
    d = 8'($urandom);
    rx_user_wr <= '{we: 1'b1, addr: p, data: d};
    @(negedge clk);
    rx_user_wr <= '0;
    @(negedge clk);
    u_host.wr(7'h50, p);
    rchk(7'h50, p);
    rchk(7'h51, d);
    u_host.wr(7'h51, ~d);
    rchk(7'h51, d);
    user_autobuf_en <= 1'b1;
    u_host.wr(7'h51, ~d);
    rchk(7'h51, ~d);
    txsel(5'd0, p);
    chk(tx_user_byte, ~d);
    user_autobuf_en <= 1'b0;
    for (i = 0; i < 3; i++) begin
      p = (i == 0) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      u_host.wr(7'h52, p);
      u_host.wr(7'h53, d);
      rchk(7'h52, p);
      rchk(7'h53, d);
      txsel(5'd0, p);
      chk(tx_user_byte, d);
    end
    $display("test user bits done");
    complete_run();
  end
endmodule // tb
